/* sbhg_pkg.sv */
/*
  Package for the speech bus / HDLC glue block: register map, field
  positions, reset values and sizes.
  Assumes a single 250 MHz clock domain and a plain strobe register port.
*/
package sbhg_pkg;
  // ==========================================================
  // Frame and channel geometry
  localparam int SBHG_TS_COUNT    = 640;
  localparam int SBHG_CH_COUNT    = 32;
  localparam int SBHG_BUF_BYTES   = 65536;
  localparam int SBHG_Q_DEPTH     = 1024;
  localparam int SBHG_Q_HALF      = 512;
  localparam int SBHG_Q_WIDTH     = 9;
  // ==========================================================
  // Register map, byte addresses on a 12-bit port
  localparam logic [11:0] SBHG_ADR_CONTROL = 12'h000;
  localparam logic [11:0] SBHG_ADR_STATUS  = 12'h004;
  localparam logic [11:0] SBHG_ADR_QUEUE   = 12'h008;
  localparam logic [11:0] SBHG_ADR_QTEST   = 12'h00C;
  localparam logic [11:0] SBHG_ADR_BUFADR  = 12'h010;
  localparam logic [11:0] SBHG_ADR_BUFDAT  = 12'h014;
  localparam logic [11:0] SBHG_ADR_RXCM    = 12'h800; // 0x800..0xBFF
  localparam logic [11:0] SBHG_ADR_TXCM    = 12'hC00; // 0xC00..0xFFF
  // ==========================================================
  // Control bit positions
  localparam int SBHG_CB_CTRL_RST  = 0;
  localparam int SBHG_CB_Q_RST     = 1;
  localparam int SBHG_CB_ATTENTION_REQUEST      = 2;
  localparam int SBHG_CB_Q_TEST    = 3;
  localparam int SBHG_CB_IRQ_EN    = 4;
  localparam int SBHG_CB_TX_DIS    = 5;
  localparam int SBHG_CB_DCH_RST   = 6;
  localparam logic [7:0] SBHG_CONTROL_RST = 8'h23;
  // Status bit positions
  localparam int SBHG_SB_NOT_EMPTY = 0;
  localparam int SBHG_SB_HALF      = 1;
  localparam int SBHG_SB_FULL      = 2;
  localparam int SBHG_SB_ACK       = 3;
  localparam logic [7:0] SBHG_STATUS_RST = 8'h00;
  // ==========================================================
  // Connection memory entry: valid bit and 5-bit channel
  typedef struct packed {
    logic       valid;
    logic [1:0] spare;
    logic [4:0] chan;
  } sbhg_cm_s;
  // Register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] adr;
    logic [31:0] wdata;
  } sbhg_req_s;
endpackage

/* sbhg_top.sv */
/*
  Speech bus / multichannel HDLC controller glue: timeslot and channel
  counters, connection and data memories, shared buffer arbiter, buffer
  return queue and cell control/status registers.
  Assumes controller and speech bus side signals are synchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module sbhg_top
  import sbhg_pkg::*;
#(
  parameter int TS_COUNT = SBHG_TS_COUNT,
  parameter int Q_DEPTH  = SBHG_Q_DEPTH
)(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Register port
  input  wire logic [11:0] reg_adr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Speech bus
  input  wire logic [7:0]  sb_rx_data_a,
  input  wire logic [7:0]  sb_rx_data_b,
  input  wire logic        sb_rx_sel_b,
  output logic      [7:0]  sb_tx_data,
  output logic             sb_tx_oe_a,
  output logic             sb_tx_oe_b,
  output logic      [9:0]  sb_timeslot,
  output logic             sb_frame_sync,
  // Controller channel bus
  output logic      [4:0]  hc_channel,
  output logic             hc_chan_strobe,
  output logic             hc_frame_strobe,
  output logic      [7:0]  hc_rx_data,
  input  wire logic        hc_tx_wr,
  input  wire logic [7:0]  hc_tx_data,
  // Controller buffer memory port
  input  wire logic        hc_mem_req,
  input  wire logic        hc_mem_wr,
  input  wire logic [15:0] hc_mem_adr,
  input  wire logic [7:0]  hc_mem_wdata,
  output logic      [7:0]  hc_mem_rdata,
  // Controller return, attention and control
  input  wire logic        hc_ret_valid,
  input  wire logic [8:0]  hc_ret_chan,
  input  wire logic        hc_irq,
  input  wire logic        hc_attention_acknowledge,
  output logic             hc_attention_request,
  output logic             hc_reset,
  output logic             d_channel_handler_reset,
  output logic             cpu_irq,
  output logic             cpu_mem_busy
);
  // ==========================================================
  // Reset release
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n) rst_sync_q <= 2'b00;
    else          rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // ==========================================================
  // Register port decode
  sbhg_req_s req;
  assign req = '{wr: reg_wr, rd: reg_rd, adr: reg_adr, wdata: reg_wdata};

  function automatic logic hit(input logic [11:0] a, input logic [11:0] base);
    hit = (a == base);
  endfunction

  // ==========================================================
  // Control register
  logic [7:0] control_q;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      control_q <= SBHG_CONTROL_RST;
    else if (req.wr && hit(req.adr, SBHG_ADR_CONTROL))
      control_q <= {1'b0, req.wdata[6:0]};
  end
  assign hc_reset                = control_q[SBHG_CB_CTRL_RST];
  assign hc_attention_request    = control_q[SBHG_CB_ATTENTION_REQUEST];
  assign d_channel_handler_reset = control_q[SBHG_CB_DCH_RST];
  // Controller interrupt gated by enable
  assign cpu_irq = hc_irq && control_q[SBHG_CB_IRQ_EN];

  // ==========================================================
  // Timeslot counter and frame control
  logic [9:0] ts_q;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ts_q <= 10'h000;
    else if (ts_q == 10'(TS_COUNT - 1))
      ts_q <= 10'h000;
    else
      ts_q <= ts_q + 10'h001;
  end
  assign sb_timeslot   = ts_q;
  assign sb_frame_sync = (ts_q == 10'h000);

  // ==========================================================
  // Connection memories, written by host, read by timeslot
  sbhg_cm_s rx_cm [0:1023];
  sbhg_cm_s tx_cm [0:1023];
  sbhg_cm_s rx_ent;
  sbhg_cm_s tx_ent;
  always_ff @(posedge ref_clk)
  begin
    if (req.wr && req.adr[11:10] == SBHG_ADR_RXCM[11:10])
      rx_cm[req.adr[9:0]] <= sbhg_cm_s'(req.wdata[7:0]);
    if (req.wr && req.adr[11:10] == SBHG_ADR_TXCM[11:10])
      tx_cm[req.adr[9:0]] <= sbhg_cm_s'(req.wdata[7:0]);
  end
  assign rx_ent = rx_cm[ts_q];
  assign tx_ent = tx_cm[ts_q];

  // ==========================================================
  // Data memories: 32 bytes each, bus and controller only
  logic [7:0] rx_dm [0:31];
  logic [7:0] tx_dm [0:31];
  logic [7:0] rx_sample;
  logic [4:0] ch_q;
  // Only one receive buffer is enabled per slot
  assign rx_sample = sb_rx_sel_b ? sb_rx_data_b : sb_rx_data_a;
  always_ff @(posedge ref_clk)
  begin
    if (rx_ent.valid)
      rx_dm[rx_ent.chan] <= rx_sample;
    if (hc_tx_wr)
      tx_dm[ch_q] <= hc_tx_data;
  end

  // Transmit drive on both bus sides, registered
  logic [7:0] tx_data_q;
  logic       tx_oe_q;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_data_q <= 8'h00;
      tx_oe_q   <= 1'b0;
    end
    else
    begin
      tx_data_q <= tx_dm[tx_ent.chan];
      tx_oe_q   <= tx_ent.valid && !control_q[SBHG_CB_TX_DIS];
    end
  end
  assign sb_tx_data = tx_data_q;
  assign sb_tx_oe_a = tx_oe_q;
  assign sb_tx_oe_b = tx_oe_q;

  // ==========================================================
  // Serial channel counter and controller strobes
  logic [7:0] hc_rx_q;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ch_q    <= 5'h00;
      hc_rx_q <= 8'h00;
    end
    else
    begin
      ch_q    <= ch_q + 5'h01;
      hc_rx_q <= rx_dm[ch_q];
    end
  end
  assign hc_channel      = ch_q;
  assign hc_chan_strobe  = 1'b1;
  assign hc_frame_strobe = (ch_q == 5'h00);
  assign hc_rx_data      = hc_rx_q;

  // ==========================================================
  // Shared buffer memory with controller priority
  logic [7:0]  buf_mem [0:SBHG_BUF_BYTES-1];
  logic [15:0] cpu_adr_q;
  logic [7:0]  cpu_rd_q;
  logic [7:0]  hc_rd_q;
  logic        cpu_buf_wr;
  assign cpu_buf_wr   = req.wr && hit(req.adr, SBHG_ADR_BUFDAT);
  assign cpu_mem_busy = hc_mem_req;
  always_ff @(posedge ref_clk)
  begin
    if (hc_mem_req && hc_mem_wr)
      buf_mem[hc_mem_adr] <= hc_mem_wdata;
    else if (!hc_mem_req && cpu_buf_wr)
      buf_mem[cpu_adr_q] <= req.wdata[7:0];
    hc_rd_q  <= buf_mem[hc_mem_adr];
    cpu_rd_q <= buf_mem[cpu_adr_q];
  end
  assign hc_mem_rdata = hc_rd_q;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cpu_adr_q <= 16'h0000;
    else if (req.wr && hit(req.adr, SBHG_ADR_BUFADR))
      cpu_adr_q <= req.wdata[15:0];
  end

  // ==========================================================
  // Buffer return queue
  localparam int QAW = $clog2(Q_DEPTH);
  logic [8:0]   q_mem [0:Q_DEPTH-1];
  logic [QAW-1:0] q_wp_q;
  logic [QAW-1:0] q_rp_q;
  logic [QAW:0]   q_cnt_q;
  logic         q_push;
  logic         q_pop;
  logic [8:0]   q_wdata;
  logic         q_full;
  logic         q_empty;
  logic         q_clr;
  logic         test_mode;
  assign test_mode = control_q[SBHG_CB_Q_TEST];
  assign q_clr     = control_q[SBHG_CB_Q_RST];
  assign q_full    = (q_cnt_q == (QAW+1)'(Q_DEPTH));
  assign q_empty   = (q_cnt_q == '0);
  // Source select: controller in normal mode, CPU in test mode
  always_comb
  begin
    if (test_mode)
    begin
      q_push  = req.wr && hit(req.adr, SBHG_ADR_QTEST);
      q_wdata = req.wdata[8:0];
    end
    else
    begin
      q_push  = hc_ret_valid;
      q_wdata = hc_ret_chan;
    end
  end
  assign q_pop = req.rd && hit(req.adr, SBHG_ADR_QUEUE) && !q_empty;
  always_ff @(posedge ref_clk)
  begin
    if (q_push && !q_full)
      q_mem[q_wp_q] <= q_wdata;
  end
  // Pointers and count; pushes while full are dropped
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q_wp_q  <= '0;
      q_rp_q  <= '0;
      q_cnt_q <= '0;
    end
    else if (q_clr)
    begin
      q_wp_q  <= '0;
      q_rp_q  <= '0;
      q_cnt_q <= '0;
    end
    else
    begin
      if (q_push && !q_full)
        q_wp_q <= q_wp_q + 1'b1;
      if (q_pop)
        q_rp_q <= q_rp_q + 1'b1;
      q_cnt_q <= q_cnt_q + (QAW+1)'(q_push && !q_full) - (QAW+1)'(q_pop);
    end
  end

  // ==========================================================
  // Status register
  logic [7:0] status_q;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      status_q <= SBHG_STATUS_RST;
    else
    begin
      status_q <= 8'h00;
      status_q[SBHG_SB_NOT_EMPTY] <= !q_empty;
      status_q[SBHG_SB_HALF] <= (q_cnt_q >= (QAW+1)'(Q_DEPTH/2));
      status_q[SBHG_SB_FULL] <= q_full;
      status_q[SBHG_SB_ACK]  <= hc_attention_acknowledge;
    end
  end

  // ==========================================================
  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0000_0000;
    else if (!req.rd)
      reg_rdata <= 32'h0000_0000;
    else if (hit(req.adr, SBHG_ADR_CONTROL))
      reg_rdata <= {24'h000000, control_q};
    else if (hit(req.adr, SBHG_ADR_STATUS))
      reg_rdata <= {24'h000000, status_q};
    else if (hit(req.adr, SBHG_ADR_QUEUE))
      reg_rdata <= {23'h000000, q_mem[q_rp_q]};
    else if (hit(req.adr, SBHG_ADR_BUFADR))
      reg_rdata <= {16'h0000, cpu_adr_q};
    else if (hit(req.adr, SBHG_ADR_BUFDAT))
      reg_rdata <= {24'h000000, cpu_rd_q};
    else
      reg_rdata <= 32'h0000_0000;
  end

  // ==========================================================
  // Checks
  property p_full_drop;
    @(posedge ref_clk) disable iff (!rst_n)
    (q_full && q_push && !q_pop && !q_clr) |=> $stable(q_cnt_q);
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("push into full queue counted");

  property p_irq_gate;
    @(posedge ref_clk) disable iff (!rst_n)
    !control_q[SBHG_CB_IRQ_EN] |-> !cpu_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq passed while disabled");

  property p_empty_bit;
    @(posedge ref_clk) disable iff (!rst_n)
    q_empty |=> !status_q[SBHG_SB_NOT_EMPTY] || $past(q_cnt_q) != q_cnt_q;
  endproperty
  a_empty_bit: assert property (p_empty_bit) else $error("empty bit wrong");

  property p_ts_wrap;
    @(posedge ref_clk) disable iff (!rst_n)
    (ts_q == 10'(TS_COUNT - 1)) |=> (ts_q == 10'h000) ##1 (ts_q == 10'h001);
  endproperty
  a_ts_wrap: assert property (p_ts_wrap) else $error("timeslot wrap wrong");

  property p_ch_step;
    @(posedge ref_clk) disable iff (!rst_n)
    (ch_q == 5'h1F) |=> hc_frame_strobe;
  endproperty
  a_ch_step: assert property (p_ch_step) else $error("channel count wrap wrong");

  property p_half;
    @(posedge ref_clk) disable iff (!rst_n)
    (q_cnt_q >= (QAW+1)'(Q_DEPTH/2)) |=> status_q[SBHG_SB_HALF];
  endproperty
  a_half: assert property (p_half) else $error("half bit missing");

  property p_ack;
    @(posedge ref_clk) disable iff (!rst_n)
    hc_attention_acknowledge |=> status_q[SBHG_SB_ACK];
  endproperty
  a_ack: assert property (p_ack) else $error("ack bit missing");

  property p_test_src;
    @(posedge ref_clk) disable iff (!rst_n)
    (test_mode && !q_clr && !q_full && !q_pop && !q_push && hc_ret_valid) |=> $stable(q_cnt_q);
  endproperty
  a_test_src: assert property (p_test_src) else $error("controller wrote in test mode");

  property p_txdis;
    @(posedge ref_clk) disable iff (!rst_n)
    control_q[SBHG_CB_TX_DIS] |=> !sb_tx_oe_a;
  endproperty
  a_txdis: assert property (p_txdis) else $error("tx drove while disabled");
endmodule // sbhg_top
`default_nettype wire

/* sbhg_ctrl_model.sv */
/*
  Behavioural model of the multichannel HDLC controller facing the glue.
  Assumes its tasks are called from one bench process, clocked by clk.
*/
`timescale 1ns/1ps
`default_nettype none
module sbhg_ctrl_model (
  // Clock
  input  wire logic        clk,
  // Towards the glue block
  output logic             ret_valid,
  output logic      [8:0]  ret_chan,
  output logic             irq,
  output logic             tx_wr,
  output logic      [7:0]  tx_data,
  output logic             mem_req,
  output logic             mem_wr,
  output logic      [15:0] mem_adr,
  output logic      [7:0]  mem_wdata,
  output logic             ack,
  // From the glue block
  input  wire logic        attention_request,
  input  wire logic [4:0]  chan,
  input  wire logic [7:0]  rdata
);
  logic [1:0] attention_request_q;
  // Idle levels at time zero
  initial
  begin
    {ret_valid, tx_wr, mem_req, mem_wr, irq} = 5'h00;
    ret_chan = 9'h000;
    tx_data = 8'h00;
    mem_adr = 16'h0000;
    mem_wdata = 8'h00;
  end
  // Acknowledge attention two cycles after seeing it
  always_ff @(posedge clk)
  begin
    attention_request_q <= {attention_request_q[0], attention_request};
  end
  assign ack = attention_request_q[1];
  // Return a buffer: queue its channel and raise the interrupt
  task automatic push(input logic [8:0] c);
    @(posedge clk);
    ret_valid <= 1'b1;
    ret_chan <= c;
    irq <= 1'b1;
    @(posedge clk);
    ret_valid <= 1'b0;
    ret_chan <= ~c;
  endtask
  task automatic set_irq(input logic v);
    @(posedge clk);
    irq <= v;
  endtask
  // Write a byte for channel c while the counter stands on it
  task automatic send_tx(input logic [4:0] c, input logic [7:0] d);
    @(negedge clk);
    while (chan !== c - 5'd1)
      @(negedge clk);
    @(posedge clk);
    tx_wr <= 1'b1;
    tx_data <= d;
    @(posedge clk);
    tx_wr <= 1'b0;
    tx_data <= ~d;
  endtask
  // Hold a buffer request to contend with the host
  task automatic set_req(input logic on);
    @(posedge clk);
    mem_req <= on;
    mem_wr <= 1'b0;
    mem_adr <= 16'h0001;
  endtask
  // Buffer write, held for one sampled edge; wins over a host write
  task automatic mem_wrt(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    mem_req <= 1'b1;
    mem_wr <= 1'b1;
    mem_adr <= a;
    mem_wdata <= d;
    @(posedge clk);
    mem_req <= 1'b0;
    mem_wr <= 1'b0;
    mem_wdata <= ~d;
  endtask
  // Buffer read, data one cycle after the request
  task automatic mem_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    mem_req <= 1'b1;
    mem_wr <= 1'b0;
    mem_adr <= a;
    @(posedge clk);
    mem_req <= 1'b0;
    mem_adr <= ~a;
    @(negedge clk);
    d = rdata;
  endtask
endmodule // sbhg_ctrl_model
`default_nettype wire

/* test_speech_bus_hdlc_glue.sv */
/*
  Self-checking bench for the speech bus / HDLC glue block.
  Assumes sbhg_pkg, the design and the controller model compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_speech_bus_hdlc_glue import sbhg_pkg::*;;
  localparam int TS = 40;
  localparam int QD = 16;
  // ==========================================================
  // Signals
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [11:0] reg_adr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  rx_a = 8'hA5;
  logic [7:0]  rx_b = 8'h5A;
  logic        sel_b = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0]  tx_data, rxd, mrd, tx_d, m_wd;
  logic [9:0]  ts;
  logic [4:0]  ch;
  logic [15:0] m_adr;
  logic [8:0]  ret_c;
  logic        oe_a, oe_b, fsync, ch_stb, f_stb, tx_wr, m_req, m_wr, ret_v;
  logic        irq, ack, attention_request, c_rst, d_rst, cpu_irq, busy;
  int          mismatches = 0;
  int          num_checks = 0;
  int          cycles = 0;
  // Clock
  always #2 ref_clk = ~ref_clk;
  // ==========================================================
  // Design and controller model
  sbhg_top #(.TS_COUNT(TS), .Q_DEPTH(QD)) i_sbhg_top (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_adr(reg_adr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sb_rx_data_a(rx_a),
    .sb_rx_data_b(rx_b), .sb_rx_sel_b(sel_b), .sb_tx_data(tx_data), .sb_tx_oe_a(oe_a),
    .sb_tx_oe_b(oe_b), .sb_timeslot(ts), .sb_frame_sync(fsync), .hc_channel(ch),
    .hc_chan_strobe(ch_stb), .hc_frame_strobe(f_stb), .hc_rx_data(rxd), .hc_tx_wr(tx_wr),
    .hc_tx_data(tx_d), .hc_mem_req(m_req), .hc_mem_wr(m_wr), .hc_mem_adr(m_adr),
    .hc_mem_wdata(m_wd), .hc_mem_rdata(mrd), .hc_ret_valid(ret_v), .hc_ret_chan(ret_c),
    .hc_irq(irq), .hc_attention_acknowledge(ack), .hc_attention_request(attention_request),
    .hc_reset(c_rst), .d_channel_handler_reset(d_rst), .cpu_irq(cpu_irq),
    .cpu_mem_busy(busy));
  sbhg_ctrl_model i_sbhg_ctrl_model (
    .clk(ref_clk), .ret_valid(ret_v), .ret_chan(ret_c), .irq(irq), .tx_wr(tx_wr),
    .tx_data(tx_d), .mem_req(m_req), .mem_wr(m_wr), .mem_adr(m_adr), .mem_wdata(m_wd),
    .ack(ack), .attention_request(attention_request), .chan(ch), .rdata(mrd));
  // ==========================================================
  // Bus cycles and comparison
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_adr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string n);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_adr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(n, e, reg_rdata);
  endtask
  task automatic wait_ch(input logic [4:0] c);
    @(negedge ref_clk);
    while (ch !== c)
      @(negedge ref_clk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rdchk(SBHG_ADR_CONTROL, 32'h23, "control reset");
    rdchk(SBHG_ADR_STATUS, 32'h00, "status reset");
    chk("reset outputs", 32'h1, {29'h0, d_rst, attention_request, c_rst});
    rdchk(12'h018, 32'h0, "unmapped read");
  endtask
  task automatic t_ctrl;
    for (int b = 0; b < 7; b++)
    begin
      wr(SBHG_ADR_CONTROL, 32'h1 << b);
      rdchk(SBHG_ADR_CONTROL, 32'h1 << b, "control bit");
      chk("control pins", {29'h0, b == 6, b == 2, b == 0}, {29'h0, d_rst, attention_request, c_rst});
    end
    wr(SBHG_ADR_CONTROL, 32'h04);
    repeat (4) @(posedge ref_clk);
    rdchk(SBHG_ADR_STATUS, 32'h08, "ack set");
    wr(SBHG_ADR_CONTROL, 32'h00);
    repeat (4) @(posedge ref_clk);
    rdchk(SBHG_ADR_STATUS, 32'h00, "ack clear");
  endtask
  task automatic t_irq;
    i_sbhg_ctrl_model.set_irq(1'b1);
    @(negedge ref_clk);
    chk("irq masked", 32'h0, {31'h0, cpu_irq});
    wr(SBHG_ADR_CONTROL, 32'h10);
    @(negedge ref_clk);
    chk("irq passed", 32'h1, {31'h0, cpu_irq});
    i_sbhg_ctrl_model.set_irq(1'b0);
    @(negedge ref_clk);
    chk("irq cleared", 32'h0, {31'h0, cpu_irq});
  endtask
  task automatic t_queue;
    wr(SBHG_ADR_CONTROL, 32'h00);
    wr(SBHG_ADR_QTEST, 32'h055);
    repeat (2) @(posedge ref_clk);
    rdchk(SBHG_ADR_STATUS, 32'h0, "host push in normal mode");
    for (int i = 1; i <= QD + 1; i++)
    begin
      i_sbhg_ctrl_model.push(9'(9'h100 + i));
      repeat (2) @(posedge ref_clk);
      rdchk(SBHG_ADR_STATUS, {29'h0, i >= QD, i >= QD / 2, 1'b1}, "fill");
    end
    for (int i = 1; i <= QD; i++)
      rdchk(SBHG_ADR_QUEUE, 32'h100 + i, "queue order");
    rdchk(SBHG_ADR_STATUS, 32'h0, "drained");
    wr(SBHG_ADR_CONTROL, 32'h08);
    i_sbhg_ctrl_model.push(9'h0F0);
    repeat (2) @(posedge ref_clk);
    rdchk(SBHG_ADR_STATUS, 32'h0, "controller push in test mode");
    wr(SBHG_ADR_QTEST, 32'h1A5);
    repeat (2) @(posedge ref_clk);
    rdchk(SBHG_ADR_QUEUE, 32'h1A5, "test mode push");
    wr(SBHG_ADR_QTEST, 32'h0AA);
    wr(SBHG_ADR_CONTROL, 32'h02);
    repeat (2) @(posedge ref_clk);
    rdchk(SBHG_ADR_STATUS, 32'h0, "queue reset");
  endtask
  task automatic t_count;
    int bad;
    logic [9:0] pt;
    logic [4:0] pc;
    bad = 0;
    @(negedge ref_clk);
    pt = ts;
    pc = ch;
    repeat (2 * TS)
    begin
      @(negedge ref_clk);
      if (ts !== 10'((pt + 1) % TS) || fsync !== (ts == 10'd0) || ch !== pc + 5'd1)
        bad++;
      if (f_stb !== (ch == 5'd0) || ch_stb !== 1'b1)
        bad++;
      pt = ts;
      pc = ch;
    end
    chk("counters", 32'h0, 32'(bad));
  endtask
  task automatic t_rx;
    wr(SBHG_ADR_CONTROL, 32'h00);
    // Clear every slot of both connection memories so unused slots stay idle
    for (int s = 0; s < TS; s++)
    begin
      wr(SBHG_ADR_RXCM + 12'(s), 32'h0);
      wr(SBHG_ADR_TXCM + 12'(s), 32'h0);
    end
    wr(SBHG_ADR_RXCM + 12'd5, 32'h83);
    repeat (2 * TS) @(posedge ref_clk);
    wait_ch(5'd4);
    chk("rx side a", 32'hA5, {24'h0, rxd});
    @(posedge ref_clk);
    sel_b <= 1'b1;
    repeat (2 * TS) @(posedge ref_clk);
    wait_ch(5'd4);
    chk("rx side b", 32'h5A, {24'h0, rxd});
  endtask
  task automatic tx_scan(output int n, output int hit, output int skew);
    {n, hit, skew} = 96'h0;
    repeat (TS)
    begin
      @(negedge ref_clk);
      n += int'(oe_a === 1'b1);
      hit += int'(oe_a === 1'b1 && tx_data === 8'h3C);
      skew += int'(oe_a !== oe_b);
    end
  endtask
  task automatic t_tx;
    int n;
    int hit;
    int skew;
    wr(SBHG_ADR_TXCM + 12'd9, 32'h86);
    i_sbhg_ctrl_model.send_tx(5'd6, 8'h3C);
    repeat (TS) @(posedge ref_clk);
    tx_scan(n, hit, skew);
    chk("tx slots", 32'h1, 32'(n));
    chk("tx byte", 32'h1, 32'(hit));
    chk("tx sides", 32'h0, 32'(skew));
    wr(SBHG_ADR_CONTROL, 32'h20);
    // Let the registered enable see the new control value first
    @(posedge ref_clk);
    tx_scan(n, hit, skew);
    chk("tx disabled", 32'h0, 32'(n));
  endtask
  task automatic t_buf;
    logic [7:0] b;
    wr(SBHG_ADR_BUFADR, 32'h1234);
    wr(SBHG_ADR_BUFDAT, 32'h77);
    i_sbhg_ctrl_model.mem_rd(16'h1234, b);
    chk("buffer write", 32'h77, {24'h0, b});
    i_sbhg_ctrl_model.set_req(1'b1);
    wr(SBHG_ADR_BUFDAT, 32'h11);
    chk("host busy", 32'h1, {31'h0, busy});
    i_sbhg_ctrl_model.set_req(1'b0);
    i_sbhg_ctrl_model.mem_rd(16'h1234, b);
    chk("controller priority", 32'h77, {24'h0, b});
    i_sbhg_ctrl_model.mem_wrt(16'h0002, 8'h99);
    wr(SBHG_ADR_BUFADR, 32'h0002);
    rdchk(SBHG_ADR_BUFDAT, 32'h99, "host sees controller byte");
  endtask
  // ==========================================================
  // Verdict and hang guard
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  // Main sequence
  initial
  begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_ctrl();
    t_irq();
    t_queue();
    t_count();
    t_rx();
    t_tx();
    t_buf();
    wrap_up();
  end
endmodule // test_speech_bus_hdlc_glue
`default_nettype wire
